// >>> common/pab_cfg.svh
// Overview of operation
// - Two non-overlapping internal phases, sample and hold, derived from master clock.
// - A new sample is taken on each falling master clock edge.
// - Four identical four-bit stages followed by a fifth four-bit flash stage.
// - Each stage samples in one phase and amplifies in the other.
// - Each stage clock is inverted against the previous stage.
// - Each identical stage word is four bits including one redundancy bit.
// - Delay line aligns all stage words of one sample into twenty bits.
// - Error correction reduces the aligned twenty bits to fourteen bits.
// - A sample's result appears on the bus four clocks after it was taken.
// - After latency one new result appears every clock cycle.
// - Output bus comes from a latch updated with the sampling clock.
// - Results are two's complement, bit 13 sign, bit 0 lsb.
// - Positive full scale gives bit 13 low and bits 0 to 12 high.
// - Negative full scale gives bit 13 high and bits 0 to 12 low.
// - Just above zero gives all zeros, just below zero all ones.
// - Bit 0 drives line 0 and bit 13 drives line 13, ascending.
`ifndef PAB_CFG_SVH
`define PAB_CFG_SVH
`define PAB_STAGES 4
`define PAB_STAGE_W 4
`define PAB_FLASH_W 4
`define PAB_OUT_W 14
`define PAB_LATENCY 4
`define PAB_STEP 3
`define PAB_RESULT_RST 14'h0000
`endif

// >>> common/pab_pkg.sv
`include "pab_cfg.svh"
package pab_pkg;
   typedef enum logic {PAB_PH_SAMPLE, PAB_PH_HOLD} pab_phase_t;
   typedef logic [`PAB_OUT_W-1:0] pab_word_t;
endpackage : pab_pkg

// >>> src/pab_delay.sv
`timescale 1ns/1ns
`default_nettype none
// Fixed-depth delay of one stage word
module pab_delay #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 1
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] pipe_r [DEPTH];
   logic [WIDTH-1:0] pipe_nxt [DEPTH];

   // Shift chain, next values
   always_comb begin
      pipe_nxt[0] = d_in;
      for (int i = 1; i < DEPTH; i++) begin
         pipe_nxt[i] = pipe_r[i-1];
      end
   end

   // Shift chain registers
   always_ff @(posedge core_clk_in) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (reset_in) begin
            pipe_r[i] <= '0;
         end else begin
            pipe_r[i] <= pipe_nxt[i];
         end
      end
   end

   assign q_out = pipe_r[DEPTH-1];
endmodule : pab_delay
`default_nettype wire

// >>> src/pab_backend.sv
`timescale 1ns/1ns
`default_nettype none
`include "pab_cfg.svh"
// Digital back end: stage phasing, delay alignment, correction, output latch
module pab_backend import pab_pkg::*; #(
   parameter int STAGES = `PAB_STAGES,
   parameter int STAGE_W = `PAB_STAGE_W,
   parameter int FLASH_W = `PAB_FLASH_W,
   parameter int LATENCY = `PAB_LATENCY
) (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [STAGES*STAGE_W-1:0] stage_words_in,
   input wire logic [FLASH_W-1:0] flash_word_in,
   output logic phase_sample_out,
   output logic phase_hold_out,
   output logic [STAGES:0] stage_amp_out,
   output logic [`PAB_OUT_W-1:0] sample_out_bus,
   output logic sample_valid_out
);
   ////////////////////////////////////////////////////////////////////////////
   // Phase generator. The master clock falls mid cycle; here every core edge
   // stands for one sample command, and the phase flop toggles twice per
   // sample time only in the analog domain, so we model the level per cycle.
   ////////////////////////////////////////////////////////////////////////////
   pab_phase_t phase_r, phase_nxt;

   // Alternate sample and hold every cycle; never both at once
   always_comb begin
      unique case (phase_r)
         PAB_PH_SAMPLE: phase_nxt = PAB_PH_HOLD;
         PAB_PH_HOLD: phase_nxt = PAB_PH_SAMPLE;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         phase_r <= PAB_PH_SAMPLE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   logic phase_sample_r, phase_hold_r;
   logic [STAGES:0] stage_amp_r;
   logic [STAGES:0] stage_amp_nxt;

   // Stage k amplifies in the opposite phase of stage k-1
   always_comb begin
      for (int k = 0; k <= STAGES; k++) begin
         stage_amp_nxt[k] = (phase_nxt == PAB_PH_HOLD) ^ k[0];
      end
   end

   // Registered so the two phase outputs are exclusive and glitch free
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         phase_sample_r <= 1'b0;
         phase_hold_r <= 1'b0;
         stage_amp_r <= '0;
      end else begin
         phase_sample_r <= (phase_nxt == PAB_PH_SAMPLE);
         phase_hold_r <= (phase_nxt == PAB_PH_HOLD);
         stage_amp_r <= stage_amp_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delay line: stage m resolves one cycle after stage m-1, so stage m waits
   // STAGES-m cycles to meet the flash word of the same sample.
   ////////////////////////////////////////////////////////////////////////////
   logic [STAGE_W-1:0] aligned_w [STAGES];

   for (genvar m = 0; m < STAGES; m++) begin : g_dly
      pab_delay #(
         .WIDTH(STAGE_W),
         .DEPTH(STAGES - m)
      ) u_dly (
         .core_clk_in(core_clk_in),
         .reset_in(reset_in),
         .d_in(stage_words_in[m*STAGE_W +: STAGE_W]),
         .q_out(aligned_w[m])
      );
   end

   logic [STAGES*STAGE_W+FLASH_W-1:0] group_w;

   // Twenty-bit group, stage 0 in the top nibble
   always_comb begin
      group_w[FLASH_W-1:0] = flash_word_in;
      for (int m = 0; m < STAGES; m++) begin
         group_w[(STAGES-m)*STAGE_W+FLASH_W-1 -: STAGE_W] = aligned_w[m];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error correction: overlap-add, each stage weighted 3 bits above the next;
   // the redundancy bit of each word overlaps the next stage's msb.
   ////////////////////////////////////////////////////////////////////////////
   localparam int SUM_W = `PAB_STEP*STAGES + FLASH_W + 1;
   logic [SUM_W-1:0] corr_sum;
   logic [`PAB_OUT_W-1:0] corr_word;

   always_comb begin
      corr_sum = {{(SUM_W-FLASH_W){1'b0}}, group_w[FLASH_W-1:0]};
      for (int m = 0; m < STAGES; m++) begin
         corr_sum = SUM_W'(corr_sum
            + (SUM_W'(group_w[(STAGES-m)*STAGE_W+FLASH_W-1 -: STAGE_W]) << (`PAB_STEP*(STAGES-m))));
      end
      // Saturate beyond full scale; offset binary to two's complement by sign flip
      if (corr_sum[SUM_W-1:`PAB_OUT_W] != '0) begin
         corr_word = {1'b0, {(`PAB_OUT_W-1){1'b1}}};
      end else begin
         corr_word = {~corr_sum[`PAB_OUT_W-1], corr_sum[`PAB_OUT_W-2:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output latch and fill counter
   ////////////////////////////////////////////////////////////////////////////
   logic [`PAB_OUT_W-1:0] out_r, out_nxt;
   logic [2:0] fill_r, fill_nxt;
   logic valid_r, valid_nxt;

   always_comb begin
      out_nxt = corr_word;
      fill_nxt = fill_r;
      if (fill_r != 3'(LATENCY)) begin
         fill_nxt = 3'(fill_r + 3'h1);
      end
      // Valid trails the counter by one edge: the word latched on the edge at
      // which the counter reaches the latency is still built from cleared stages
      valid_nxt = (fill_r == 3'(LATENCY));
   end

   // One word per edge, held until the next edge
   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         out_r <= `PAB_RESULT_RST;
         fill_r <= 3'h0;
         valid_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         fill_r <= fill_nxt;
         valid_r <= valid_nxt;
      end
   end

   assign phase_sample_out = phase_sample_r;
   assign phase_hold_out = phase_hold_r;
   assign stage_amp_out = stage_amp_r;
   assign sample_out_bus = out_r;
   assign sample_valid_out = valid_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   ////////////////////////////////////////////////////////////////////////////

   // Phase outputs are exact complements from the first edge after release
   phase_exclusive_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !$past(reset_in) |-> (phase_sample_out != phase_hold_out))
      else $error("phases overlap");
   hold_track_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !$past(reset_in) |-> (phase_hold_out == (phase_r == PAB_PH_HOLD)))
      else $error("hold phase off its state");

   // From the second edge after release, every edge swaps sampling and amplifying, in the pair and in each stage
   phase_alternate_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !$past(reset_in, 2) |-> (phase_sample_out != $past(phase_sample_out)))
      else $error("phase did not alternate");
   stage_swap_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !$past(reset_in, 2) |-> (stage_amp_out == ~$past(stage_amp_out)))
      else $error("stage phase did not swap");

   // Neighbouring stages always do opposite work
   stage_invert_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !$past(reset_in) |-> (stage_amp_out[0] != stage_amp_out[1] && stage_amp_out[1] != stage_amp_out[2]))
      else $error("stage clocks not inverted");
   stage_tail_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !$past(reset_in) |-> (stage_amp_out[2] != stage_amp_out[3] && stage_amp_out[3] != stage_amp_out[4]))
      else $error("late stage clocks not inverted");

   // Valid rises on the fifth edge after release, so four fill words stay unflagged
   latency_four_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $rose(sample_valid_out) |-> ($past(reset_in, 6) && !$past(reset_in, 5)))
      else $error("latency not four");
   valid_early_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (fill_r != 3'(LATENCY)) |-> !sample_valid_out)
      else $error("valid before pipeline filled");
   valid_stays_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      sample_valid_out |=> sample_valid_out)
      else $error("valid dropped");

   // The bus shows the word corrected at the previous edge, cleared by reset
   out_latch_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      !$past(reset_in) |-> (sample_out_bus == $past(corr_word)))
      else $error("output not latched");
   reset_clear_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      $past(reset_in) |-> (sample_out_bus == `PAB_RESULT_RST))
      else $error("output not cleared by reset");

   // Code points at both ends of the range and on either side of zero
   pos_sat_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (corr_sum[SUM_W-1:`PAB_OUT_W] != '0) |=> (sample_out_bus == 14'h1FFF))
      else $error("no positive saturation");
   pos_peak_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (corr_sum == SUM_W'(17'h03FFF)) |=> (sample_out_bus == 14'h1FFF))
      else $error("top code wrong");
   neg_full_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (corr_sum == SUM_W'(17'h00000)) |=> (sample_out_bus == 14'h2000))
      else $error("bottom code wrong");
   sign_flip_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (corr_sum == SUM_W'(17'h02000)) |=> (sample_out_bus == 14'h0000))
      else $error("mid code wrong");
   all_ones_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (corr_sum == SUM_W'(17'h01FFF)) |=> (sample_out_bus == 14'h3FFF))
      else $error("code below zero wrong");

   // Fill counter parks at the latency value and never wraps
   fill_bound_a: assert property (@(posedge core_clk_in) disable iff (reset_in)
      fill_r <= 3'(LATENCY))
      else $error("fill counter overran");
endmodule : pab_backend
`default_nettype wire

// >>> dv/pab_host_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host capture logic: keeps only flagged words, drops the pipeline fill words
module pab_host_model import pab_pkg::*; (
   input wire logic core_clk_in,
   input wire logic reset_in,
   input wire logic [13:0] sample_bus_in,
   input wire logic sample_valid_in,
   output var int kept_out,
   output var pab_word_t last_out
);
   // Capture on the rising edge; the bus is held a full period, so this edge is safe
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         kept_out <= 0;
         last_out <= 14'h0000;
      end else if (sample_valid_in === 1'b1) begin
         kept_out <= kept_out + 1;
         last_out <= sample_bus_in;
      end
   end
endmodule : pab_host_model
`default_nettype wire

// >>> dv/pipeline_adc_digital_backend_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pipeline_adc_digital_backend_tb import pab_pkg::*;;
   logic core_clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [15:0] stage_words_in = 16'h0000;
   logic [3:0] flash_word_in = 4'h0;
   logic phase_sample_out, phase_hold_out, sample_valid_out;
   logic [4:0] stage_amp_out;
   pab_word_t sample_out_bus, last;
   int kept;
   logic [3:0] tab [0:15][0:4];
   pab_word_t lit [0:15];
   logic use_lit = 1'b0;
   int n_fail = 0;
   int checked = 0;
   ////////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   always #5 core_clk_in = ~core_clk_in;
   pab_backend DUT (.core_clk_in(core_clk_in), .reset_in(reset_in), .stage_words_in(stage_words_in),
      .flash_word_in(flash_word_in), .phase_sample_out(phase_sample_out), .phase_hold_out(phase_hold_out),
      .stage_amp_out(stage_amp_out), .sample_out_bus(sample_out_bus), .sample_valid_out(sample_valid_out));
   pab_host_model host (.core_clk_in(core_clk_in), .reset_in(reset_in), .sample_bus_in(sample_out_bus),
      .sample_valid_in(sample_valid_out), .kept_out(kept), .last_out(last));
   ////////////////////////////////////////////////////////////////////////////
   // Compare tasks, one for words and one for single flags
   task automatic chk_word(input pab_word_t got, input pab_word_t exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   // Weighted sum with overlap step 3, saturate high, flip sign bit for two's complement
   function automatic pab_word_t expect_word(input int i);
      logic [16:0] s;
      s = 17'(tab[i][4]) + (17'(tab[i][3]) << 3) + (17'(tab[i][2]) << 6) + (17'(tab[i][1]) << 9);
      s = s + (17'(tab[i][0]) << 12);
      return (s > 17'h03FFF) ? 14'h1FFF : {~s[13], s[12:0]};
   endfunction : expect_word
   // Literal expectations where a scenario gives them, else the overlap-add model
   function automatic pab_word_t want_of(input int i);
      return use_lit ? lit[i] : expect_word(i);
   endfunction : want_of
   // Reset for four edges; phase, valid and bus outputs must be zero after the fourth
   task automatic do_reset();
      reset_in = 1'b1;
      stage_words_in = 16'h0000;
      flash_word_in = 4'h0;
      repeat (4) @(posedge core_clk_in);
      #1;
      chk_bit(phase_sample_out | phase_hold_out | sample_valid_out, 1'b0);
      chk_word(sample_out_bus, 14'h0000);
      reset_in = 1'b0;
   endtask : do_reset
   // Staggered stage feed of n samples; sample i shows after edge i+5
   task automatic play(input int n);
      pab_word_t held;
      logic ps;
      for (int e = 1; e <= n + 5; e++) begin
         for (int m = 0; m < 4; m++) begin
            stage_words_in[4*m +: 4] = (e - m - 1 >= 0 && e - m - 1 < n) ? tab[e-m-1][m] : 4'h0;
         end
         flash_word_in = (e - 5 >= 0 && e - 5 < n) ? tab[e-5][4] : 4'h0;
         #4;
         if (e > 1) chk_word(sample_out_bus, held);
         ps = phase_sample_out;
         @(posedge core_clk_in);
         #1;
         held = sample_out_bus;
         if (e == 4 || e == 5) chk_bit(sample_valid_out, e == 5);
         if (e > 1) chk_bit(phase_sample_out, ~ps);
         chk_bit(phase_hold_out, ~phase_sample_out);
         for (int k = 0; k < 4 && e > 1; k++) chk_bit(stage_amp_out[k+1], ~stage_amp_out[k]);
         if (e >= 5 && e < n + 5) chk_word(held, want_of(e - 5));
      end
      chk_word(last, want_of(n - 1));
      chk_word(14'(kept), 14'(n));
   endtask : play
   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_codes();
      tab[0] = '{4'h3, 4'h7, 4'h7, 4'h7, 4'h7};
      tab[1] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
      tab[2] = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h0};
      tab[3] = '{4'h1, 4'h7, 4'h7, 4'h7, 4'h7};
      tab[4] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
      lit[0] = 14'h1FFF;
      lit[1] = 14'h2000;
      lit[2] = 14'h0000;
      lit[3] = 14'h3FFF;
      lit[4] = 14'h1FFF;
      use_lit = 1'b1;
      do_reset();
      play(5);
      $display("codes test done");
   endtask : test_codes
   task automatic test_align();
      for (int i = 0; i < 8; i++) for (int m = 0; m < 5; m++) tab[i][m] = 4'((i + 3 * m) % 8);
      use_lit = 1'b0;
      do_reset();
      play(8);
      $display("align test done");
   endtask : test_align
   // One output line high at a time, bit 0 up to the sign bit
   task automatic test_bits();
      logic [15:0] s;
      for (int b = 0; b < 14; b++) begin
         s = (b == 13) ? 16'h0000 : (16'h2000 | (16'h0001 << b));
         tab[b] = '{4'(s >> 12), 4'((s >> 9) & 7), 4'((s >> 6) & 7), 4'((s >> 3) & 7), 4'(s & 7)};
         lit[b] = 14'(14'h0001 << b);
      end
      use_lit = 1'b1;
      do_reset();
      play(14);
      $display("bits test done");
   endtask : test_bits
   // Reset after a finished stream drops the host count and clears the outputs
   task automatic test_rereset();
      do_reset();
      play(3);
      do_reset();
      chk_word(14'(kept), 14'h0000);
      play(2);
      $display("rereset test done");
   endtask : test_rereset
   task automatic tally_and_finish();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence, and a watchdog far beyond the 77 cycles it needs
   initial begin
      test_codes();
      test_align();
      test_bits();
      test_rereset();
      tally_and_finish();
   end
   initial begin
      #100000;
      n_fail++;
      tally_and_finish();
   end
endmodule : pipeline_adc_digital_backend_tb
`default_nettype wire
